// *** src/asram_pkg.sv ***
package asram_pkg;

    // ************************************************************
    // Geometry
    // ************************************************************
    localparam int ADDR_W = 15;
    localparam int DATA_W = 8;

    // ************************************************************
    // Timing of the fastest grade, in ns, and the clock period
    // ************************************************************
    localparam int CLK_PERIOD_NS   = 10;
    localparam int T_READ_CYCLE_NS = 20;  // Read and write cycle time
    localparam int T_ADDR_ACC_NS   = 20;  // Address and select access
    localparam int T_OE_ACC_NS     = 10;  // Output enable access
    localparam int T_WRITE_PULSE_NS = 15; // Strobe low, output enable low
    localparam int T_WP_OE_HIGH_NS = 12;  // Strobe low, output enable high
    localparam int T_ADDR_TO_END_NS = 15; // Address valid to end of write
    localparam int T_DATA_SETUP_NS = 8;   // Data valid to end of write
    localparam int T_OE_FLOAT_NS   = 8;   // Output enable high to float
    localparam int T_WE_RECOVER_NS = 4;   // Strobe high to output active

    // Least times round up to whole cycles, never below one
    function automatic int cyc_up(input int ns);
        int c;
        c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
        return (c < 1) ? 1 : c;
    endfunction : cyc_up

    localparam int CYC_W = 4;
    localparam logic [CYC_W-1:0] CYC_READ   = CYC_W'(cyc_up(T_ADDR_ACC_NS));
    localparam logic [CYC_W-1:0] CYC_CYCLE  = CYC_W'(cyc_up(T_READ_CYCLE_NS));
    localparam logic [CYC_W-1:0] CYC_WP     = CYC_W'(cyc_up(T_WRITE_PULSE_NS));
    localparam logic [CYC_W-1:0] CYC_WP_OEH = CYC_W'(cyc_up(T_WP_OE_HIGH_NS));
    localparam logic [CYC_W-1:0] CYC_FLOAT  = CYC_W'(cyc_up(T_OE_FLOAT_NS));
    localparam logic [CYC_W-1:0] CYC_RECOV  = CYC_W'(cyc_up(T_WE_RECOVER_NS));
    localparam logic [CYC_W-1:0] CYC_ZERO   = '0;
    localparam logic [CYC_W-1:0] CYC_ONE    = CYC_W'(1);

    // ************************************************************
    // Carriers
    // ************************************************************
    typedef struct packed {
        logic              write;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } asram_req_t;

    typedef struct packed {
        logic              sel_n;
        logic              oe_n;
        logic              we_n;
        logic [ADDR_W-1:0] word_address;
    } asram_pins_t;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_READ,
        ST_READ_END,
        ST_WRITE,
        ST_WRITE_END,
        ST_GAP
    } asram_state_t;

endpackage : asram_pkg

// *** src/asram_sync2.sv ***
`timescale 1ns/10ps
module asram_sync2 #(
    parameter int WIDTH = 8
) (
    // Clock and reset
    input  wire logic             clk_sys,
    input  wire logic             sys_rst,
    // Data
    input  wire logic [WIDTH-1:0] din,
    output logic      [WIDTH-1:0] dout
);

    logic [WIDTH-1:0] meta;

    // Two-stage synchroniser; first stage feeds only the second
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            meta <= '0;
            dout <= '0;
        end else begin
            meta <= din;
            dout <= meta;
        end
    end

endmodule : asram_sync2

// *** src/asram_host.sv ***
// Operation
// (RULE_01) Chip select high leaves memory unselected and its data pins floating.
// (RULE_02) Select low, output enable and strobe high: memory floats, stores nothing.
// (RULE_03) Select and output enable low, strobe high: memory drives addressed byte.
// (RULE_04) Select and strobe low: memory writes and floats, output enable ignored.
// (RULE_05) Write lasts while select and strobe are low; ends at first rise.
// (RULE_06) Output enable falling at or after strobe fall keeps pins undriven.
// (RULE_07) Select-timed write inside strobe keeps outputs floating.
// (RULE_08) Output enable high through write allows 12 ns strobe pulse.
// (RULE_09) Host holds write strobe high during whole read cycle.
// (RULE_10) Read data valid within 20 ns of last address change.
// (RULE_11) Read data valid within 20 ns of select falling.
// (RULE_12) Read data valid within 10 ns of output enable falling.
// (RULE_13) Old read data held at least 4 ns after address change.
// (RULE_14) Outputs float within 9 ns of select rise, 8 ns of enable rise.
// (RULE_15) Outputs float within 8 ns of strobe fall; redrive 4 ns after rise.
// (RULE_16) Host keeps address stable at least one cycle time, 20 ns.
// (RULE_17) Strobe low at least 15 ns; address setup and release 0 ns.
// (RULE_18) Address valid at least 15 ns before write ends.
// (RULE_19) Write data valid 8 ns before write end, held 0 ns after.
// (RULE_20) Select-ended write holds select low at least 12 ns.
// (RULE_21) After retention supply restore, wait one read cycle before access.
// (RULE_22) Delays become whole clock cycles rounded up; pins sequenced to meet them.
`timescale 1ns/10ps
module asram_host
    import asram_pkg::*;
(
    // Clock and reset
    input  wire logic                      clk_sys,
    input  wire logic                      sys_rst,
    // User request side
    input  wire asram_pkg::asram_req_t     req,
    input  wire logic                      req_valid,
    output logic                           req_ready,
    output logic [asram_pkg::DATA_W-1:0]   rd_data,
    output logic                           rd_valid,
    output logic                           wr_done,
    // Retention control
    input  wire logic                      retain_req,
    output logic                           retain_active,
    // Memory pins
    output asram_pkg::asram_pins_t         pins,
    input  wire logic [asram_pkg::DATA_W-1:0] byte_pins_i,
    output logic [asram_pkg::DATA_W-1:0]   byte_pins_o,
    output logic                           byte_pins_oe
);
    import asram_pkg::*;

    // ************************************************************
    // Synchronised inputs from the pins
    // ************************************************************
    logic [DATA_W-1:0] byte_sync;

    asram_sync2 #(
        .WIDTH (DATA_W)
    ) u_sync (
        .clk_sys (clk_sys),
        .sys_rst (sys_rst),
        .din     (byte_pins_i),
        .dout    (byte_sync)
    );

    // ************************************************************
    // Sequencer state
    // ************************************************************
    asram_state_t      state;
    logic [CYC_W-1:0]  cnt;
    logic              retain_hold;

    // Read capture waits the two synchroniser stages beyond access time
    localparam logic [CYC_W-1:0] CYC_CAPTURE = CYC_READ + CYC_W'(2);
    // Strobe pulse: output enable stays high during writes, so shorter pulse applies
    localparam logic [CYC_W-1:0] CYC_STROBE  = (CYC_WP_OEH > CYC_WP) ? CYC_WP : CYC_WP_OEH;

    // Main state machine
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            state <= ST_IDLE;
            cnt   <= CYC_ZERO;
        end else begin
            unique case (state)
                ST_IDLE: begin
                    if (req_valid && req_ready) begin
                        state <= req.write ? ST_WRITE : ST_READ;
                        cnt   <= req.write ? CYC_STROBE : CYC_CAPTURE;
                    end
                end
                ST_READ: begin
                    // Address held, strobe high, wait access then capture
                    if (cnt == CYC_ONE) begin // RULE_10 RULE_11 RULE_12
                        state <= ST_READ_END;
                        cnt   <= CYC_FLOAT;
                    end else begin
                        cnt <= cnt - CYC_ONE;
                    end
                end
                ST_READ_END: begin
                    // Output enable high; let the memory float before next use
                    if (cnt == CYC_ONE) begin // RULE_14
                        state <= ST_GAP;
                        cnt   <= CYC_RECOV;
                    end else begin
                        cnt <= cnt - CYC_ONE;
                    end
                end
                ST_WRITE: begin
                    if (cnt == CYC_ONE) begin // RULE_08 RULE_17 RULE_18 RULE_19
                        state <= ST_WRITE_END;
                        cnt   <= CYC_ONE;
                    end else begin
                        cnt <= cnt - CYC_ONE;
                    end
                end
                ST_WRITE_END: begin
                    // Strobe high; data and address held one more cycle
                    state <= ST_GAP;
                    cnt   <= CYC_RECOV;
                end
                ST_GAP: begin
                    if (cnt <= CYC_ONE) begin
                        state <= ST_IDLE;
                        cnt   <= CYC_ZERO;
                    end else begin
                        cnt <= cnt - CYC_ONE;
                    end
                end
                // Unused codes fall back to idle with select high
                default: begin
                    state <= ST_IDLE;
                    cnt   <= CYC_ZERO;
                end
            endcase
        end
    end

    // Accepts a request only when idle and not in retention
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            req_ready <= 1'b0;
        end else begin
            req_ready <= (state == ST_IDLE) && !(req_valid && req_ready)
                         && !retain_req && !retain_hold; // RULE_21
        end
    end

    // ************************************************************
    // Retention: select held high, then one cycle time of recovery
    // ************************************************************
    logic [CYC_W-1:0] rec_cnt;

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            retain_hold   <= 1'b0;
            retain_active <= 1'b0;
            rec_cnt       <= CYC_ZERO;
        end else begin
            // Not granted on the edge that takes a request: select is about to fall
            retain_active <= retain_req && (state == ST_IDLE) && !(req_valid && req_ready);
            if (retain_req) begin
                retain_hold <= 1'b1;
                rec_cnt     <= CYC_CYCLE; // RULE_21
            end else if (rec_cnt != CYC_ZERO) begin
                rec_cnt <= rec_cnt - CYC_ONE;
            end else begin
                retain_hold <= 1'b0;
            end
        end
    end

    // ************************************************************
    // Pin drive
    // ************************************************************
    // Address and select held from request to end of gap
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            pins.word_address <= '0;
            pins.sel_n        <= 1'b1; // RULE_01
        end else begin
            if (state == ST_IDLE && req_valid && req_ready) begin
                pins.word_address <= req.addr; // RULE_16
                pins.sel_n        <= 1'b0; // RULE_20
            end else if (state == ST_GAP || state == ST_IDLE) begin
                pins.sel_n <= 1'b1; // Address kept: 0 ns release
            end
        end
    end

    // Output enable only during reads; strobe only during writes
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            pins.oe_n <= 1'b1;
            pins.we_n <= 1'b1;
        end else begin
            pins.oe_n <= !(state == ST_IDLE && req_valid && req_ready && !req.write)
                         && !(state == ST_READ && cnt != CYC_ONE); // RULE_03
            pins.we_n <= !(state == ST_IDLE && req_valid && req_ready && req.write)
                         && !(state == ST_WRITE && cnt != CYC_ONE); // RULE_09 RULE_05 RULE_06
        end
    end

    // Host drives data only while strobe is low or just after it rises
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            byte_pins_o  <= '0;
            byte_pins_oe <= 1'b0;
        end else begin
            if (state == ST_IDLE && req_valid && req_ready && req.write) begin
                byte_pins_o  <= req.wdata; // RULE_19
                byte_pins_oe <= 1'b1; // RULE_04 RULE_15
            end else if (state == ST_WRITE_END) begin
                byte_pins_oe <= 1'b0; // Held one cycle past strobe rise
            end
        end
    end

    // ************************************************************
    // Answers to the user
    // ************************************************************
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            rd_data  <= '0;
            rd_valid <= 1'b0;
            wr_done  <= 1'b0;
        end else begin
            rd_valid <= (state == ST_READ) && (cnt == CYC_ONE);
            wr_done  <= (state == ST_WRITE_END);
            if (state == ST_READ && cnt == CYC_ONE) begin
                rd_data <= byte_sync; // RULE_13 RULE_22
            end
        end
    end

endmodule : asram_host

// *** testbench/asram_chk.sv ***
`timescale 1ns/10ps
// Watches the host's pins and handshake
module asram_chk
    import asram_pkg::*;
(
    // Clock and reset
    input wire logic                          clk_sys,
    input wire logic                          sys_rst,
    // User side
    input wire asram_pkg::asram_req_t         req,
    input wire logic                          req_valid,
    input wire logic                          req_ready,
    input wire logic                          rd_valid,
    input wire logic                          wr_done,
    input wire logic                          retain_req,
    input wire logic                          retain_active,
    // Memory side
    input wire asram_pkg::asram_pins_t        pins,
    input wire logic [asram_pkg::DATA_W-1:0]  byte_pins_o,
    input wire logic                          byte_pins_oe
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (sys_rst);

    a_read_strobe_high: assert property (!pins.oe_n |-> pins.we_n)
        else $error("Strobe low while output enabled");
    a_strobe_width: assert property ($fell(pins.we_n) |=> !pins.we_n ##1 pins.we_n)
        else $error("Strobe pulse not two cycles");
    a_write_addr_hold: assert property (
        !pins.sel_n && !$fell(pins.we_n) && !$past(pins.we_n) |-> $stable(pins.word_address))
        else $error("Address moved during write");
    a_data_setup: assert property (
        $rose(pins.we_n) |-> byte_pins_oe && $past(byte_pins_oe) && $stable(byte_pins_o))
        else $error("Write data not held around strobe rise");
    a_no_contention: assert property (byte_pins_oe |-> pins.oe_n)
        else $error("Host drives while memory enabled");
    a_select_covers: assert property (!pins.we_n |-> !pins.sel_n ##1 !pins.sel_n)
        else $error("Select ends before strobe");
    a_addr_cycle: assert property ($changed(pins.word_address) |=> $stable(pins.word_address))
        else $error("Address held under one cycle time");
    a_read_answer: assert property (req_valid && req_ready && !req.write |-> ##5 rd_valid)
        else $error("Read answer late or missing");
    a_write_answer: assert property (req_valid && req_ready && req.write |-> ##4 wr_done)
        else $error("Write answer late or missing");
    a_retain_select: assert property (retain_active |-> pins.sel_n)
        else $error("Select low in retention");
    a_retain_recover: assert property ($fell(retain_req) |-> !req_ready ##1 !req_ready)
        else $error("Request taken before recovery");
endmodule : asram_chk

bind asram_host asram_chk i_chk (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .req(req), .req_valid(req_valid), .req_ready(req_ready),
    .rd_valid(rd_valid), .wr_done(wr_done), .retain_req(retain_req), .retain_active(retain_active),
    .pins(pins), .byte_pins_o(byte_pins_o), .byte_pins_oe(byte_pins_oe));

// *** testbench/asram_mem.sv ***
`timescale 1ns/10ps
// Behavioural memory at the far side of the host
module asram_mem
    import asram_pkg::*;
#(
    parameter int ACC_NS = 18  // Slow answer, inside the 20 ns access
) (
    // Memory pins
    input wire asram_pkg::asram_pins_t        pins,
    input wire logic [asram_pkg::DATA_W-1:0]  bus,
    // Read drive
    output logic                              drv,
    output logic [asram_pkg::DATA_W-1:0]      q
);
    logic [DATA_W-1:0] mem [2**ADDR_W];
    logic              wr;

    // Write lasts while select and strobe are both low
    assign wr = !pins.sel_n && !pins.we_n;
    // Store when the first of the two rises
    always @(negedge wr) mem[pins.word_address] = bus;
    // Drive only when selected, enabled and not writing
    assign drv = !pins.sel_n && !pins.oe_n && pins.we_n;
    // Old byte held, new byte after the access delay
    assign #(ACC_NS) q = mem[pins.word_address];
endmodule : asram_mem

// *** testbench/asram_host_tb_top.sv ***
`timescale 1ns/10ps
// Self-checking bench for the memory host
module asram_host_tb_top;
    import asram_pkg::*;
    logic              clk_sys = 0;
    logic              sys_rst = 1;
    asram_req_t        req = '0;
    logic              req_valid = 0;
    logic              retain_req = 0;
    logic              req_ready, rd_valid, wr_done, retain_active, byte_pins_oe, drv;
    logic [DATA_W-1:0] rd_data, byte_pins_o, q, bus, junk;
    asram_pins_t       pins;
    logic [DATA_W-1:0] shadow [2**ADDR_W];
    logic [ADDR_W-1:0] adr [10];
    logic [DATA_W:0]   expq [$];
    logic [DATA_W:0]   e;
    int                n_fail = 0;
    int                cmp_count = 0;
    int                cycles = 0;

    always #5 clk_sys = ~clk_sys;
    // Released bus shows a fresh pattern each cycle
    always @(posedge clk_sys) junk <= DATA_W'($urandom);
    assign bus = byte_pins_oe ? byte_pins_o : (drv ? q : junk);

    asram_host i_dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .req(req), .req_valid(req_valid),
        .req_ready(req_ready), .rd_data(rd_data), .rd_valid(rd_valid), .wr_done(wr_done),
        .retain_req(retain_req), .retain_active(retain_active), .pins(pins),
        .byte_pins_i(bus), .byte_pins_o(byte_pins_o), .byte_pins_oe(byte_pins_oe));
    asram_mem i_mem (.pins(pins), .bus(bus), .drv(drv), .q(q));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic conclude;
        $display("Comparisons %0d, mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : conclude

    // Hold a request until taken, then note its answer
    task automatic xfer(input logic wr, input logic [ADDR_W-1:0] ad, input logic [DATA_W-1:0] dt);
        int n;
        n = 0;
        @(posedge clk_sys);
        #1;
        req = '{write: wr, addr: ad, wdata: dt};
        req_valid = 1;
        while (req_ready !== 1'b1 && n < 50) begin
            @(posedge clk_sys);
            #1;
            n++;
        end
        @(posedge clk_sys);
        if (wr) shadow[ad] = dt;
        expq.push_back({wr, shadow[ad]});
        #1;
        req_valid = 0;
    endtask : xfer

    // Compare each answer with the oldest note
    always @(negedge clk_sys) begin
        if (rd_valid === 1'b1 || wr_done === 1'b1) begin
            e = expq.size() ? expq.pop_front() : '1;
            check(32'({wr_done, rd_valid ? rd_data : e[DATA_W-1:0]}), 32'(e));
        end
    end

    // Cut a hang short
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles > 5000) begin
            n_fail++;
            conclude();
        end
    end

    initial begin
        void'($urandom(5));
        repeat (4) @(posedge clk_sys);
        #1 sys_rst = 0;
        check(32'({pins.sel_n, pins.oe_n, pins.we_n, byte_pins_oe}), 32'he);
        for (int i = 0; i < 10; i++) begin
            adr[i] = (i == 0) ? '0 : (i == 1) ? 15'h7fff : ADDR_W'($urandom);
            xfer(1'b1, adr[i], DATA_W'($urandom));
        end
        // Overwrite half, then read all back to back
        for (int i = 0; i < 5; i++) xfer(1'b1, adr[i], ~shadow[adr[i]]);
        for (int i = 0; i < 10; i++) xfer(1'b0, adr[i], 8'h00);
        // Retention keeps contents, requests wait
        @(posedge clk_sys);
        #1 retain_req = 1;
        for (int k = 0; k < 50 && retain_active !== 1'b1; k++) begin
            @(posedge clk_sys);
            #1;
        end
        check(32'({retain_active, req_ready, pins.sel_n}), 32'h5);
        repeat (20) @(posedge clk_sys);
        #1 retain_req = 0;
        for (int i = 0; i < 10; i++) xfer(1'b0, adr[i], 8'h00);
        for (int k = 0; k < 50 && expq.size() != 0; k++) @(posedge clk_sys);
        check(32'(expq.size()), 32'h0);
        // Reset in mid-write leaves the pins idle, then a read still works
        xfer(1'b1, adr[2], DATA_W'($urandom));
        @(posedge clk_sys);
        #1 sys_rst = 1;
        repeat (4) @(posedge clk_sys);
        #1 sys_rst = 0;
        expq.delete();
        check(32'({pins.sel_n, pins.oe_n, pins.we_n, byte_pins_oe, rd_valid, wr_done}), 32'h38);
        xfer(1'b0, adr[1], 8'h00);
        for (int k = 0; k < 50 && expq.size() != 0; k++) @(posedge clk_sys);
        check(32'(expq.size()), 32'h0);
        conclude();
    end
endmodule : asram_host_tb_top
